// file: inc/exc_regs_pkg.sv
package exc_regs_pkg;

	// Register byte offsets
	localparam logic [11:0] OFS_INT_CTRL_STATE = 12'h004;
	localparam logic [11:0] OFS_VECTOR_BASE = 12'h008;
	localparam logic [11:0] OFS_EVT_STATUS = 12'h010;
	localparam logic [11:0] OFS_EVT_MASK = 12'h014;

	// Field positions in interrupt_control_state
	localparam int NMI_SET_POS = 31;
	localparam int DEF_SET_POS = 28;
	localparam int DEF_CLR_POS = 27;
	localparam int TMR_SET_POS = 26;
	localparam int TMR_CLR_POS = 25;
	localparam int HALT_SVC_POS = 23;
	localparam int EXT_PEND_POS = 22;
	localparam int TOP_NUM_LSB = 12;
	localparam int ACT_NUM_LSB = 0;
	localparam int EXC_NUM_W = 9;

	// Build options
	localparam logic TIMER_PRESENT = 1'b1;
	localparam logic DEBUG_PRESENT = 1'b1;
	localparam logic [31:0] TABLE_FIELD_MASK = 32'hffffff80;
	localparam logic [31:0] TABLE_IMPL_MASK = 32'h3fffff80;

	// Exception numbers
	localparam logic [8:0] EXC_NONE = 9'h000;
	localparam logic [8:0] EXC_THREAD = 9'h000;
	localparam int EXC_NMI = 2;
	localparam int EXC_DEFCALL = 14;
	localparam int EXC_TIMER = 15;
	localparam int EXC_IRQ_BASE = 16;
	localparam int NUM_IRQ = 32;
	localparam int PEND_W = EXC_IRQ_BASE + NUM_IRQ;

	// Event status and mask bits
	localparam int EVT_NMI = 0;
	localparam int EVT_DEFCALL = 1;
	localparam int EVT_TIMER = 2;
	localparam int EVT_W = 3;

	// Reset values
	localparam logic [31:0] VBASE_RESET = 32'h00000000;
	localparam logic [EVT_W-1:0] EVT_RESET = 3'h0;

	typedef enum logic [1:0] {
		PH_IDLE = 2'b01,
		PH_ACCESS = 2'b10
	} apb_phase_e;

	typedef struct packed {
		logic nmi;
		logic defcall;
		logic timer;
		logic [NUM_IRQ-1:0] irq_pend;
		logic [NUM_IRQ-1:0] irq_en;
	} pend_src_s;

	typedef struct packed {
		apb_phase_e phase;
		logic pready;
		logic slverr;
		logic [31:0] rdata;
		logic nmi_pend;
		logic def_pend;
		logic tmr_pend;
		logic [31:0] vbase;
		logic strap_done;
		logic [8:0] top_num;
		logic [8:0] act_num;
		logic ext_pend;
		logic halt_svc;
		logic [EVT_W-1:0] evt_stat;
		logic [EVT_W-1:0] evt_mask;
		logic irq;
	} regs_s;

	function automatic logic w1(input logic [31:0] d, input int pos);
		return d[pos];
	endfunction : w1

endpackage : exc_regs_pkg

// file: core/exc_pend_picker.sv
`timescale 1ns/1ps
module exc_pend_picker
	import exc_regs_pkg::*;
(
	// Pending sources
	input pend_src_s src,
	// Winner
	output logic [8:0] top_num
);

	logic [PEND_W-1:0] vec;

	// Lower exception number wins; the global priority mask is not an input
	always_comb
	begin
		vec = '0;
		vec[EXC_NMI] = src.nmi;
		vec[EXC_DEFCALL] = src.defcall;
		vec[EXC_TIMER] = src.timer;
		vec[PEND_W-1:EXC_IRQ_BASE] = src.irq_pend & src.irq_en;
		top_num = EXC_NONE;
		for (int i = PEND_W - 1; i >= 0; i--)
		begin
			if (vec[i])
			begin
				top_num = 9'(i);
			end
		end
	end

endmodule : exc_pend_picker

// file: core/exc_state_regs.sv
`timescale 1ns/1ps
// Overview of operation
// - Bit 31 write one pends nonmaskable interrupt
// - Nonmaskable request raised on the clock after the write, nothing blocks it
// - Bit 28 write one pends deferred call
// - Bit 27 write one clears deferred call
// - Bit 26 pends timer; zero if absent
// - Bit 25 clears timer pending, any source
// - Bit 23 shows service on halt exit
// - Bit 22 shows external interrupt pending
// - Bits 20:12 give top pending number
// - Top pending ignores global priority mask
// - Bits 8:0 give active exception number
// - Table offset bits 31:7, low reserved
// - Unimplemented offset bits read zero
// - Offset resets to zero, then loads configuration strap on first clock
// - Unsupplied table address bits are zero
// - All-ones write reads back implemented bits
module exc_state_regs
	import exc_regs_pkg::*;
(
	// Clock and reset
	input logic SYS_CLK,
	input logic RESET,
	// APB slave
	input logic PSEL,
	input logic PENABLE,
	input logic PWRITE,
	input logic [11:0] PADDR,
	input logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Exception logic side
	input logic TIMER_EVENT,
	input logic NMI_ACK,
	input logic DEFCALL_ACK,
	input logic TIMER_ACK,
	input logic HALTED,
	input logic [8:0] ACTIVE_EXC,
	input logic [31:0] IRQ_PEND,
	input logic [31:0] IRQ_ENABLE,
	output logic NMI_REQ,
	output logic DEFCALL_REQ,
	output logic TIMER_REQ,
	// Vector table
	input logic [31:0] TABLE_BASE_STRAP,
	output logic [31:0] VECTOR_BASE,
	// Interrupt
	output logic IRQ
);

	localparam regs_s REGS_RESET = '{
		phase: PH_IDLE,
		vbase: VBASE_RESET,
		evt_stat: EVT_RESET,
		evt_mask: EVT_RESET,
		default: '0
	};

	regs_s s_q;
	regs_s s_d;
	pend_src_s src;
	logic [8:0] pick_num;
	logic setup;
	logic fire;
	logic hit;
	logic wr_interrupt_control_state;
	logic wr_vbase;
	logic wr_stat;
	logic wr_mask;
	logic nmi_set;
	logic def_set;
	logic def_clr;
	logic tmr_set;
	logic tmr_clr;
	logic [EVT_W-1:0] evt;

	function automatic logic [31:0] interrupt_control_state_word(input regs_s s);
		logic [31:0] w;
		w = '0;
		w[NMI_SET_POS] = s.nmi_pend;
		w[DEF_SET_POS] = s.def_pend;
		w[TMR_SET_POS] = TIMER_PRESENT & s.tmr_pend;
		w[HALT_SVC_POS] = DEBUG_PRESENT & s.halt_svc;
		w[EXT_PEND_POS] = DEBUG_PRESENT & s.ext_pend;
		w[TOP_NUM_LSB +: EXC_NUM_W] = s.top_num;
		if (DEBUG_PRESENT)
		begin
			w[ACT_NUM_LSB +: EXC_NUM_W] = s.act_num;
		end
		return w;
	endfunction : interrupt_control_state_word

	function automatic logic [31:0] read_word(input regs_s s,
		input logic [11:0] a);
		logic [31:0] w;
		w = '0;
		case (a)
			OFS_INT_CTRL_STATE: w = interrupt_control_state_word(s);
			OFS_VECTOR_BASE: w = s.vbase;
			OFS_EVT_STATUS: w[EVT_W-1:0] = s.evt_stat;
			OFS_EVT_MASK: w[EVT_W-1:0] = s.evt_mask;
			default: w = '0;
		endcase
		return w;
	endfunction : read_word

	assign setup = PSEL && !PENABLE;
	assign fire = PSEL && PENABLE && s_q.pready;
	assign hit = (PADDR == OFS_INT_CTRL_STATE) ||
		(PADDR == OFS_VECTOR_BASE) || (PADDR == OFS_EVT_STATUS) ||
		(PADDR == OFS_EVT_MASK);
	assign wr_interrupt_control_state = fire && PWRITE && (PADDR == OFS_INT_CTRL_STATE);
	assign wr_vbase = fire && PWRITE && (PADDR == OFS_VECTOR_BASE);
	assign wr_stat = fire && PWRITE && (PADDR == OFS_EVT_STATUS);
	assign wr_mask = fire && PWRITE && (PADDR == OFS_EVT_MASK);

	// Writing zero to any set or clear bit leaves the state alone
	assign nmi_set = wr_interrupt_control_state && w1(PWDATA, NMI_SET_POS);
	assign def_set = wr_interrupt_control_state && w1(PWDATA, DEF_SET_POS);
	assign def_clr = wr_interrupt_control_state && w1(PWDATA, DEF_CLR_POS);
	assign tmr_set = TIMER_PRESENT &&
		((wr_interrupt_control_state && w1(PWDATA, TMR_SET_POS)) || TIMER_EVENT);
	assign tmr_clr = TIMER_PRESENT && wr_interrupt_control_state &&
		w1(PWDATA, TMR_CLR_POS);
	assign evt = {tmr_set, def_set, nmi_set};

	assign src = '{
		nmi: s_q.nmi_pend,
		defcall: s_q.def_pend,
		timer: s_q.tmr_pend,
		irq_pend: IRQ_PEND,
		irq_en: IRQ_ENABLE
	};

	// No global priority mask input reaches the picker
	exc_pend_picker u_picker (
		.src(src),
		.top_num(pick_num)
	);

	always_comb
	begin
		s_d = s_q;
		s_d.pready = 1'b0;
		s_d.slverr = 1'b0;
		case (s_q.phase)
			PH_IDLE:
			begin
				if (setup)
				begin
					// Answer is prepared at setup so the access phase is one cycle
					s_d.phase = PH_ACCESS;
					s_d.pready = 1'b1;
					s_d.slverr = !hit;
					s_d.rdata = PWRITE ? 32'h0 : read_word(s_q, PADDR);
				end
			end
			PH_ACCESS:
			begin
				if (fire || !PSEL)
				begin
					s_d.phase = PH_IDLE;
				end
				else
				begin
					s_d.pready = s_q.pready;
					s_d.slverr = s_q.slverr;
				end
			end
			default:
			begin
				s_d.phase = PH_IDLE;
			end
		endcase

		// Set beats every clear, including a set and clear in one write
		s_d.nmi_pend = nmi_set || (s_q.nmi_pend && !NMI_ACK);
		s_d.def_pend = def_set ||
			(s_q.def_pend && !def_clr && !DEFCALL_ACK);
		s_d.tmr_pend = tmr_set ||
			(s_q.tmr_pend && !tmr_clr && !TIMER_ACK);

		// Strap is sampled on the first clock after reset release
		if (!s_q.strap_done)
		begin
			s_d.strap_done = 1'b1;
			s_d.vbase = TABLE_BASE_STRAP & TABLE_IMPL_MASK;
		end
		else if (wr_vbase)
		begin
			s_d.vbase = PWDATA & TABLE_IMPL_MASK;
		end

		s_d.top_num = pick_num;
		s_d.act_num = ACTIVE_EXC;
		s_d.ext_pend = |IRQ_PEND;
		s_d.halt_svc = HALTED && (pick_num != EXC_NONE) &&
			((ACTIVE_EXC == EXC_THREAD) || (pick_num < ACTIVE_EXC));

		if (wr_stat)
		begin
			s_d.evt_stat = s_q.evt_stat & ~PWDATA[EVT_W-1:0];
		end
		s_d.evt_stat = s_d.evt_stat | evt;
		if (wr_mask)
		begin
			s_d.evt_mask = PWDATA[EVT_W-1:0];
		end
		s_d.irq = |(s_d.evt_stat & s_d.evt_mask);
	end

	always_ff @(posedge SYS_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			s_q <= REGS_RESET;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign PRDATA = s_q.rdata;
	assign PREADY = s_q.pready;
	assign PSLVERR = s_q.slverr;
	assign NMI_REQ = s_q.nmi_pend;
	assign DEFCALL_REQ = s_q.def_pend;
	assign TIMER_REQ = s_q.tmr_pend;
	assign VECTOR_BASE = s_q.vbase;
	assign IRQ = s_q.irq;

	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (RESET);

	sequence apb_setup;
		PSEL && !PENABLE && (s_q.phase == PH_IDLE);
	endsequence

	sequence apb_access;
		PSEL && PENABLE && PREADY;
	endsequence

	// Once pending, nmi stays up and owns the top number a cycle later
	sequence nmi_stays_top;
		NMI_REQ ##1 s_q.top_num == 9'(EXC_NMI);
	endsequence

	a_apb_answer: assert property (apb_setup |=> PREADY ##1 !PREADY)
		else $error("apb answer not one cycle after setup");

	a_unmapped_err: assert property (
		apb_setup ##0 !hit |=> PSLVERR && PRDATA == 32'h0)
		else $error("unmapped access not refused");

	a_nmi_pend_set: assert property (nmi_set |=> NMI_REQ)
		else $error("nmi pend write did not raise request");

	a_nmi_zero_write: assert property (
		wr_interrupt_control_state && !nmi_set && !NMI_ACK |=> $stable(NMI_REQ))
		else $error("zero write changed nmi pending");

	a_nmi_ack_clear: assert property (
		NMI_ACK && !nmi_set |=> !NMI_REQ)
		else $error("taken nmi still pending");

	a_nmi_top_wins: assert property (
		NMI_REQ && !NMI_ACK |=> nmi_stays_top)
		else $error("pending nmi not top exception");

	a_defcall_set: assert property (
		apb_access ##0 def_set |=> DEFCALL_REQ)
		else $error("deferred call not pended");

	a_defcall_zero: assert property (
		wr_interrupt_control_state && !def_set && !def_clr && !DEFCALL_ACK |=>
		$stable(DEFCALL_REQ))
		else $error("zero write changed deferred call");

	a_defcall_clear: assert property (
		def_clr && !def_set |=> !DEFCALL_REQ)
		else $error("deferred call not cleared");

	a_defcall_ack: assert property (
		DEFCALL_ACK && !def_set |=> !DEFCALL_REQ)
		else $error("taken deferred call still pending");

	a_timer_set: assert property (TIMER_EVENT |=> TIMER_REQ)
		else $error("timer event not pended");

	a_timer_sw_set: assert property (
		wr_interrupt_control_state && PWDATA[TMR_SET_POS] |=> TIMER_REQ)
		else $error("timer pend write not taken");

	a_timer_clear: assert property (
		tmr_clr && !tmr_set |=> !TIMER_REQ)
		else $error("timer pend not cleared");

	a_timer_ack: assert property (
		TIMER_ACK && !tmr_set |=> !TIMER_REQ)
		else $error("taken timer exception still pending");

	a_halt_svc: assert property (
		s_q.halt_svc |-> $past(HALTED) && s_q.top_num != EXC_NONE)
		else $error("halt service flag without cause");

	a_ext_pend: assert property (
		(|IRQ_PEND) |=> s_q.ext_pend)
		else $error("external pending not reported");

	a_top_number: assert property (
		(|(IRQ_PEND & IRQ_ENABLE)) && !s_q.nmi_pend && !s_q.def_pend &&
		!s_q.tmr_pend |=> s_q.top_num >= 9'(EXC_IRQ_BASE))
		else $error("top pending number wrong");

	a_active_copy: assert property (
		##1 s_q.act_num == $past(ACTIVE_EXC))
		else $error("active number not tracked");

	a_vbase_bits: assert property (
		(VECTOR_BASE & ~TABLE_IMPL_MASK) == 32'h0)
		else $error("vector base has unsupported bits");

	a_vbase_write: assert property (
		wr_vbase |=> VECTOR_BASE == ($past(PWDATA) & TABLE_IMPL_MASK))
		else $error("vector base write wrong");

	// Reset may drop in the step of an edge; its sampled level keeps
	// that edge from counting as the strap load
	a_vbase_strap: assert property (
		!RESET && !s_q.strap_done |=>
		VECTOR_BASE == ($past(TABLE_BASE_STRAP) & TABLE_IMPL_MASK))
		else $error("vector base strap not loaded");

	a_rsvd_zero: assert property (
		PREADY && !PWRITE && PADDR == OFS_INT_CTRL_STATE |->
		(PRDATA & 32'h6b200e00) == 32'h0)
		else $error("reserved bits not zero");

	a_irq_level: assert property (
		IRQ == |(s_q.evt_stat & s_q.evt_mask))
		else $error("interrupt level wrong");

	a_status_sticky: assert property (
		s_q.evt_stat[EVT_NMI] && !wr_stat |=> s_q.evt_stat[EVT_NMI])
		else $error("event status bit lost");

	a_status_w1c: assert property (
		wr_stat && PWDATA[EVT_NMI] && !nmi_set |=> !s_q.evt_stat[EVT_NMI])
		else $error("event status bit not cleared");

endmodule : exc_state_regs

// file: dv/tb.sv
`timescale 1ns/1ps
module tb
	import exc_regs_pkg::*;
;
	logic SYS_CLK = 1'b0;
	logic RESET = 1'b1;
	logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, HALTED = 1'b0;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h0, IRQ_PEND = 32'h0, IRQ_ENABLE = 32'h0;
	logic [31:0] PRDATA, VECTOR_BASE, r;
	logic PREADY, PSLVERR, NMI_REQ, DEFCALL_REQ, TIMER_REQ, IRQ, e, i0;
	logic [8:0] ACTIVE_EXC = 9'h000;
	logic [31:0] strap = 32'hffffffff;
	// Pulses: timer event, nmi ack, deferred call ack, timer ack
	logic [3:0] pv = 4'h0;
	int failures = 0, tests_run = 0, cyc = 0;

	exc_state_regs i_dut (.SYS_CLK(SYS_CLK), .RESET(RESET), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.TIMER_EVENT(pv[0]), .NMI_ACK(pv[1]), .DEFCALL_ACK(pv[2]),
		.TIMER_ACK(pv[3]), .HALTED(HALTED), .ACTIVE_EXC(ACTIVE_EXC),
		.IRQ_PEND(IRQ_PEND), .IRQ_ENABLE(IRQ_ENABLE), .NMI_REQ(NMI_REQ),
		.DEFCALL_REQ(DEFCALL_REQ), .TIMER_REQ(TIMER_REQ),
		.TABLE_BASE_STRAP(strap), .VECTOR_BASE(VECTOR_BASE),
		.IRQ(IRQ));

	always #12.5 SYS_CLK = ~SYS_CLK;

	// Guards against a slave that never answers
	always @(posedge SYS_CLK)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			failures++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("Comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		tests_run++;
		if (s !== x)
		begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask : chk

	task automatic idle();
		repeat (3) @(posedge SYS_CLK);
	endtask : idle

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge SYS_CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge SYS_CLK);
		PENABLE <= 1'b1;
		// Only the bench timeout ends a wait for the answer
		do
		begin
			@(posedge SYS_CLK);
		end
		while (PREADY !== 1'b1);
		r = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb

	// Status fields lag a cycle, so every write is followed by idle time
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		idle();
	endtask : wr

	task automatic rdc(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(r, x);
	endtask : rdc

	task automatic pls(input logic [3:0] m);
		pv <= m;
		@(posedge SYS_CLK);
		pv <= 4'h0;
		idle();
	endtask : pls

	task automatic t_reset();
		rdc(OFS_INT_CTRL_STATE, 32'h0);
		rdc(OFS_VECTOR_BASE, 32'h3fffff80);
		chk(VECTOR_BASE, 32'h3fffff80);
		wr(OFS_INT_CTRL_STATE, 32'h61200e00);
		rdc(OFS_INT_CTRL_STATE, 32'h0);
		$display("reset test done");
	endtask : t_reset

	task automatic t_vbase();
		wr(OFS_VECTOR_BASE, 32'h0);
		rdc(OFS_VECTOR_BASE, 32'h0);
		wr(OFS_VECTOR_BASE, 32'hffffffff);
		rdc(OFS_VECTOR_BASE, 32'h3fffff80);
		wr(OFS_VECTOR_BASE, 32'h12345678);
		rdc(OFS_VECTOR_BASE, 32'h12345600);
		chk(VECTOR_BASE, 32'h12345600);
		$display("vector base test done");
	endtask : t_vbase

	// Sets and clears go in separate writes
	task automatic t_pend();
		wr(OFS_INT_CTRL_STATE, 32'h80000000);
		chk(NMI_REQ, 1'b1);
		rdc(OFS_INT_CTRL_STATE, 32'h80002000);
		wr(OFS_INT_CTRL_STATE, 32'h0);
		rdc(OFS_INT_CTRL_STATE, 32'h80002000);
		wr(OFS_INT_CTRL_STATE, 32'h10000000);
		rdc(OFS_INT_CTRL_STATE, 32'h90002000);
		pls(4'h2);
		rdc(OFS_INT_CTRL_STATE, 32'h1000e000);
		chk(DEFCALL_REQ, 1'b1);
		wr(OFS_INT_CTRL_STATE, 32'h08000000);
		rdc(OFS_INT_CTRL_STATE, 32'h0);
		pls(4'h1);
		rdc(OFS_INT_CTRL_STATE, 32'h0400f000);
		wr(OFS_INT_CTRL_STATE, 32'h02000000);
		rdc(OFS_INT_CTRL_STATE, 32'h0);
		wr(OFS_INT_CTRL_STATE, 32'h04000000);
		rdc(OFS_INT_CTRL_STATE, 32'h0400f000);
		wr(OFS_INT_CTRL_STATE, 32'h02000000);
		chk(TIMER_REQ, 1'b0);
		$display("pending test done");
	endtask : t_pend

	// Core acknowledges take the deferred call and timer pending states away on their own
	task automatic t_ack();
		wr(OFS_INT_CTRL_STATE, 32'h14000000);
		rdc(OFS_INT_CTRL_STATE, 32'h1400e000);
		pls(4'h4);
		chk(DEFCALL_REQ, 1'b0);
		rdc(OFS_INT_CTRL_STATE, 32'h0400f000);
		pls(4'h8);
		chk(TIMER_REQ, 1'b0);
		rdc(OFS_INT_CTRL_STATE, 32'h0);
		$display("acknowledge test done");
	endtask : t_ack

	// A reset in mid-run reloads the offset from a new strap value
	task automatic t_rst2();
		wr(OFS_VECTOR_BASE, 32'h00000080);
		strap <= 32'hd2345680;
		RESET <= 1'b1;
		@(posedge SYS_CLK);
		chk(VECTOR_BASE, 32'h0);
		chk(IRQ, 1'b0);
		@(posedge SYS_CLK);
		RESET <= 1'b0;
		@(posedge SYS_CLK);
		rdc(OFS_VECTOR_BASE, 32'h12345680);
		chk(VECTOR_BASE, 32'h12345680);
		$display("second reset test done");
	endtask : t_rst2

	task automatic t_status();
		IRQ_PEND <= 32'h8;
		IRQ_ENABLE <= 32'h8;
		ACTIVE_EXC <= 9'h005;
		HALTED <= 1'b1;
		idle();
		rdc(OFS_INT_CTRL_STATE, 32'h00413005);
		ACTIVE_EXC <= 9'h000;
		idle();
		rdc(OFS_INT_CTRL_STATE, 32'h00c13000);
		IRQ_ENABLE <= 32'h0;
		HALTED <= 1'b0;
		idle();
		rdc(OFS_INT_CTRL_STATE, 32'h00400000);
		IRQ_PEND <= 32'h0;
		idle();
		$display("status test done");
	endtask : t_status

	// Mask polarity is not assumed: exactly one mask setting must raise it
	task automatic t_irq();
		wr(OFS_EVT_MASK, 32'h0);
		wr(OFS_EVT_STATUS, 32'h7);
		wr(OFS_INT_CTRL_STATE, 32'h80000000);
		rdc(OFS_EVT_STATUS, 32'h1);
		i0 = IRQ;
		wr(OFS_EVT_MASK, 32'h7);
		chk(i0 ^ IRQ, 1'b1);
		wr(OFS_EVT_STATUS, 32'h1);
		rdc(OFS_EVT_STATUS, 32'h0);
		chk(IRQ, 1'b0);
		pls(4'h2);
		chk(NMI_REQ, 1'b0);
		apb(1'b0, 12'h00c, 32'h0);
		chk(e, 1'b1);
		chk(r, 32'h0);
		$display("interrupt test done");
	endtask : t_irq

	initial
	begin
		repeat (2) @(posedge SYS_CLK);
		RESET <= 1'b0;
		@(posedge SYS_CLK);
		t_reset();
		t_vbase();
		t_pend();
		t_ack();
		t_status();
		t_irq();
		t_rst2();
		finish_test();
	end
endmodule : tb
